// ==== bench/acc_core_model.sv ====
// Behavioural analog core answering with the latched routing word
`timescale 1ns/1ps
module acc_core_model
(
  input  wire logic                     pclk,
  input  wire logic                     sample_start,
  input  wire logic                     conv_run,
  input  wire acc_pkg::acc_mux_sel_type mux_sel,
  output      logic [9:0]               result
);
  import acc_pkg::*;
  logic [9:0] held_q;
  // Routing word as sample value, so a stale select shows in the result
  always_ff @(posedge pclk)
  begin
    if (sample_start)
      held_q <= mux_sel;
  end
  // Outside a conversion the output is junk: drive the inverse
  assign result = conv_run ? held_q : ~held_q;
endmodule

// ==== bench/acc_top_assertions.sv ====
// Port-level assertions for the converter control block
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_checker
(
  input wire logic                     pclk,
  input wire logic                     presetn,
  input wire logic                     psel,
  input wire logic                     penable,
  input wire logic                     pwrite,
  input wire logic [7:0]               paddr,
  input wire logic [31:0]              prdata,
  input wire logic                     converter_power,
  input wire logic                     sample_start,
  input wire logic                     conversion_running,
  input wire acc_pkg::acc_mux_sel_type core_mux_sel
);
  import acc_pkg::*;
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire csr_rd = psel && penable && !pwrite
                && paddr == {`ACC_IDX_CSRA, 2'b00};
  chk_busy_read: assert property (
    csr_rd |-> prdata[6] == conversion_running)
    else $error("start bit does not follow busy");
  chk_sel_hold: assert property (
    conversion_running && $past(conversion_running) |-> $stable(core_mux_sel))
    else $error("routing changed mid conversion");
  chk_min_len: assert property (
    $rose(conversion_running)
    |-> (conversion_running || !converter_power)[*8])
    else $error("conversion ended too early");
  // Cycles spent running; longest legal run is 25 ticks of 128 clocks
  logic [11:0] run_len_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      run_len_q <= 12'h000;
    else if (conversion_running)
      run_len_q <= 12'(run_len_q + 12'h001);
    else
      run_len_q <= 12'h000;
  end
  chk_max_len: assert property (
    conversion_running |-> run_len_q < 12'hC80)
    else $error("conversion ran too long");
  chk_rise_pulse: assert property (
    $rose(conversion_running) |-> sample_start)
    else $error("no sample pulse at conversion start");
  chk_start_once: assert property (
    sample_start |=> !sample_start)
    else $error("sample pulse longer than one cycle");
  chk_run_power: assert property (
    conversion_running |-> converter_power)
    else $error("conversion running while powered off");
  chk_single_neg: assert property (
    sample_start && !core_mux_sel.differential
    |-> core_mux_sel.neg_input == `ACC_IN_AGND)
    else $error("single-ended input not referred to ground");
  cover property ($fell(conversion_running) && converter_power);
  cover property ($fell(converter_power));
  cover property (sample_start && core_mux_sel.differential);
endmodule

bind acc_top acc_checker u_chk (.pclk, .presetn, .psel, .penable, .pwrite,
  .paddr, .prdata, .converter_power, .sample_start, .conversion_running,
  .core_mux_sel);

// ==== bench/acc_top_tb.sv ====
// Self-checking bench for the converter channel and conversion control
`timescale 1ns/1ps
`include "acc_params.svh"
module acc_top_tb;
  import acc_pkg::*;
  logic            pclk = 1'b0;
  logic            presetn = 1'b0;
  logic            psel = 1'b0;
  logic            penable = 1'b0;
  logic            pwrite = 1'b0;
  logic [7:0]      paddr = 8'h00;
  logic [31:0]     pwdata = 32'h0;
  logic            gie = 1'b0;
  logic            ack = 1'b0;
  logic [7:1]      trig = 7'h00;
  logic [9:0]      res;
  logic [1:0]      rsel;
  logic [31:0]     prdata;
  logic            pready, pslverr, pwr, sstart, run, irq, last_err;
  acc_mux_sel_type msel;
  logic [7:0]      p;
  int              n;
  int              n_errors = 0;
  int              n_checks = 0;
  logic [5:0]      code [10] = '{6'h07, 6'h20, 6'h21, 6'h22, 6'h09,
                                 6'h29, 6'h23, 6'h24, 6'h27, 6'h1E};
  logic [9:0]      want [10] = '{10'h1E0, 10'h220, 10'h260, 10'h2A0, 10'h007,
                                 10'h043, 10'h003, 10'h0CE, 10'h1DF, 10'h19E};

  acc_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .pstrb(4'hF), .prdata, .pready, .pslverr, .global_irq_enable(gie),
    .irq_vector_ack(ack), .trigger_sources(trig), .core_result(res),
    .converter_power(pwr), .sample_start(sstart), .conversion_running(run),
    .core_mux_sel(msel), .core_reference_select(rsel), .irq);
  acc_core_model u_core (.pclk, .sample_start(sstart), .conv_run(run),
    .mux_sel(msel), .result(res));

  always #5 pclk = ~pclk;

  task automatic finish_test;
    $display("checks=%0d errors=%0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [5:0] idx,
                     input logic [7:0] wd, output logic [31:0] rd);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do
      @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic wr(input logic [5:0] idx, input logic [7:0] wd);
    logic [31:0] d;
    apb(1'b1, idx, wd, d);
  endtask

  task automatic rdc(input logic [5:0] idx, input logic [31:0] exp);
    logic [31:0] d;
    apb(1'b0, idx, 8'h00, d);
    chk(d, exp);
  endtask

  // Length counted from the edge after the starting write
  task automatic wait_end(input time t0, output int len);
    do
      @(posedge pclk);
    while (run === 1'b1 && $time - t0 < 40000);
    len = int'(($time - t0) / 10);
  endtask

  initial
  begin
    #300000;
    n_errors++;
    finish_test();
  end

  initial
  begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdc(`ACC_IDX_CSRA, 32'h00);
    rdc(`ACC_IDX_CHSEL, 32'h00);
    rdc(`ACC_IDX_IRQ_MASK, 32'h03);
    rdc(6'h0F, 32'h00);
    chk(last_err, 1'b1);
    wr(`ACC_IDX_CHSEL, {2'b00, code[0]});
    for (int i = 0; i < 10; i++)
    begin
      p = 8'(i % 8);
      wr(`ACC_IDX_CSRA, 8'hD0 | p);
      n = int'($time);
      rdc(`ACC_IDX_CSRA, 32'hC0 | p);
      wr(`ACC_IDX_CSRA, 8'h80 | p);
      wr(`ACC_IDX_CHSEL, {2'b00, code[(i + 1) % 10]});
      wait_end(n, n);
      chk(n, (i == 0 ? 25 : 13) * (p < 2 ? 2 : 1 << p));
      rdc(`ACC_IDX_CSRA, 32'h90 | p);
      rdc(`ACC_IDX_RES_LO, want[i][7:0]);
      rdc(`ACC_IDX_RES_HI, want[i][9:8]);
    end
    rdc(`ACC_IDX_RES_LO, want[9][7:0]);
    wr(`ACC_IDX_CHSEL, 8'hC7);
    wr(`ACC_IDX_CSRA, 8'hD0);
    wr(`ACC_IDX_CHSEL, 8'h47);
    wait_end($time, n);
    chk(rsel, 2'h3);
    rdc(`ACC_IDX_RES_LO, want[9][7:0]);
    rdc(`ACC_IDX_RES_HI, want[9][9:8]);
    // Whole-value write keeps the done flag pending
    wr(`ACC_IDX_CSRA, 8'h88);
    gie <= 1'b1;
    @(posedge pclk);
    chk(irq, 1'b1);
    gie <= 1'b0;
    @(posedge pclk);
    chk(irq, 1'b0);
    gie <= 1'b1;
    wr(`ACC_IDX_IRQ_MASK, 8'h02);
    chk(irq, 1'b0);
    wr(`ACC_IDX_IRQ_MASK, 8'h03);
    chk(irq, 1'b1);
    ack <= 1'b1;
    @(posedge pclk);
    ack <= 1'b0;
    @(posedge pclk);
    chk(irq, 1'b0);
    wr(`ACC_IDX_CSRA, 8'hD8);
    wait_end($time, n);
    chk(irq, 1'b1);
    chk(rsel, 2'h1);
    wr(`ACC_IDX_IRQ_STAT, 8'h01);
    chk(irq, 1'b0);
    wr(`ACC_IDX_CSRA, 8'hC0);
    wr(`ACC_IDX_CSRA, 8'h00);
    chk({pwr, run}, 2'b00);
    rdc(`ACC_IDX_IRQ_STAT, 32'h02);
    chk(irq, 1'b1);
    wr(`ACC_IDX_IRQ_STAT, 8'h03);
    wr(`ACC_IDX_TRIG, 8'h03);
    wr(`ACC_IDX_CSRA, 8'hB0);
    trig[3] <= 1'b1;
    repeat (3) @(posedge pclk);
    chk(run, 1'b1);
    wait_end($time, n);
    trig[3] <= 1'b0;
    wr(`ACC_IDX_TRIG, 8'h00);
    repeat (4) @(posedge pclk);
    chk(run, 1'b0);
    finish_test();
  end
endmodule

// ==== src/acc_params.svh ====
// Offsets, field positions, reset values and counts of the converter control
`ifndef ACC_PARAMS_SVH
`define ACC_PARAMS_SVH

// Register indices; byte address is four times the index
`define ACC_IDX_TRIG      6'h03
`define ACC_IDX_RES_LO    6'h04
`define ACC_IDX_RES_HI    6'h05
`define ACC_IDX_CSRA      6'h06
`define ACC_IDX_CHSEL     6'h07
`define ACC_IDX_IRQ_STAT  6'h08
`define ACC_IDX_IRQ_MASK  6'h09

// Control and status A field positions
`define ACC_CSRA_EN       7
`define ACC_CSRA_START    6
`define ACC_CSRA_ATE      5
`define ACC_CSRA_FLAG     4
`define ACC_CSRA_IE       3

// Event status and mask bit positions
`define ACC_IRQ_DONE      0
`define ACC_IRQ_ABORT     1

// Reset values
`define ACC_CSRA_RST      8'h00
`define ACC_CHSEL_RST     8'h00
`define ACC_TRIG_RST      3'h0
`define ACC_MASK_RST      2'h3

// Conversion lengths in converter clock cycles
`define ACC_FIRST_CYCLES  5'h19
`define ACC_NORMAL_CYCLES 5'h0D

// Selection codes with a fixed meaning
`define ACC_CODE_AGND     6'h20
`define ACC_CODE_BANDGAP  6'h21
`define ACC_CODE_TEMP     6'h22
`define ACC_CODE_OFS0     6'h23

// Analog input numbers seen by the core beyond the eight pins
`define ACC_IN_AGND       4'h8
`define ACC_IN_BANDGAP    4'h9
`define ACC_IN_TEMP       4'hA

`endif

// ==== src/acc_pkg.sv ====
// Types shared by the converter control block and its bench
package acc_pkg;

  // Routing handed to the analog core, latched at conversion start
  typedef struct packed {
    logic [3:0] pos_input;
    logic [3:0] neg_input;
    logic       differential;
    logic       gain_x20;
  } acc_mux_sel_type;

  // Conversion sequencer
  typedef enum logic [0:0] {
    ACC_IDLE    = 1'b0,
    ACC_CONVERT = 1'b1
  } acc_state_type;

endpackage

// ==== src/acc_top.sv ====
// Converter channel, gain and conversion control with an APB register slave
//
// The implementer's own choice: the APB register port.
`timescale 1ns/1ps
`include "acc_params.svh"

module acc_top
(
  input  wire logic                     pclk,
  input  wire logic                     presetn,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [7:0]               paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output      logic [31:0]              prdata,
  output      logic                     pready,
  output      logic                     pslverr,
  input  wire logic                     global_irq_enable,
  input  wire logic                     irq_vector_ack,
  input  wire logic [7:1]               trigger_sources,
  input  wire logic [9:0]               core_result,
  output      logic                     converter_power,
  output      logic                     sample_start,
  output      logic                     conversion_running,
  output      acc_pkg::acc_mux_sel_type core_mux_sel,
  output      logic [1:0]               core_reference_select,
  output      logic                     irq
);
  import acc_pkg::*;

  // Differential pair table, {positive, negative}, for codes 8 to 31
  localparam logic [5:0] PAIRS [12] = '{
    6'h01, 6'h03, 6'h0A, 6'h0B, 6'h13, 6'h1C,
    6'h1D, 6'h1E, 6'h1F, 6'h25, 6'h2E, 6'h37
  };

  function automatic acc_mux_sel_type decode_sel(input logic [5:0] code);
    acc_mux_sel_type s;
    logic [5:0]      pair;
    logic [3:0]      k;
    s    = '0;
    pair = '0;
    k    = 4'(code[4:1] - 4'h4);
    s.neg_input = `ACC_IN_AGND;
    if (code[5:3] == 3'h0)
      s.pos_input = {1'b0, code[2:0]};
    else if (code == `ACC_CODE_AGND)
      s.pos_input = `ACC_IN_AGND;
    else if (code == `ACC_CODE_BANDGAP)
      s.pos_input = `ACC_IN_BANDGAP;
    else if (code == `ACC_CODE_TEMP)
      s.pos_input = `ACC_IN_TEMP;
    else if (code[5:3] == 3'h4)
    begin
      // Same pin on both sides for offset measurement
      s.differential = 1'b1;
      s.gain_x20     = code[0];
      if (code == `ACC_CODE_OFS0)
        s.pos_input = 4'h0;
      else if (code[2:1] == 2'h2)
        s.pos_input = 4'h3;
      else
        s.pos_input = 4'h7;
      s.neg_input = s.pos_input;
    end
    else
    begin
      pair           = PAIRS[k];
      s.differential = 1'b1;
      s.gain_x20     = code[0];
      if (code[5])
      begin
        s.pos_input = {1'b0, pair[2:0]};
        s.neg_input = {1'b0, pair[5:3]};
      end
      else
      begin
        s.pos_input = {1'b0, pair[5:3]};
        s.neg_input = {1'b0, pair[2:0]};
      end
    end
    return s;
  endfunction

  // Registers
  logic            enable_q;
  logic            auto_trig_q;
  logic            done_flag_q;
  logic            done_flag_d;
  logic            irq_en_q;
  logic [2:0]      prescale_q;
  logic [7:0]      chsel_q;
  logic [2:0]      trig_src_q;
  logic [2:0]      trig_src_prev_q;
  logic            trig_prev_q;
  logic            abort_flag_q;
  logic            abort_flag_d;
  logic [1:0]      mask_q;
  logic [9:0]      result_q;
  logic            result_lock_q;
  logic            first_q;
  acc_state_type   state_q;
  logic [4:0]      cycle_q;
  logic [4:0]      length_q;
  logic [6:0]      div_cnt_q;
  logic            sample_start_q;
  acc_mux_sel_type mux_sel_q;
  logic [1:0]      ref_sel_q;

  // Bus decode
  wire        access    = psel & penable;
  wire [5:0]  index     = paddr[7:2];
  wire        aligned   = paddr[1:0] == 2'h0;
  wire        hit_trig  = aligned & (index == `ACC_IDX_TRIG);
  wire        hit_lo    = aligned & (index == `ACC_IDX_RES_LO);
  wire        hit_hi    = aligned & (index == `ACC_IDX_RES_HI);
  wire        hit_csra  = aligned & (index == `ACC_IDX_CSRA);
  wire        hit_chsel = aligned & (index == `ACC_IDX_CHSEL);
  wire        hit_stat  = aligned & (index == `ACC_IDX_IRQ_STAT);
  wire        hit_mask  = aligned & (index == `ACC_IDX_IRQ_MASK);
  wire        mapped    = hit_trig | hit_lo | hit_hi | hit_csra |
                          hit_chsel | hit_stat | hit_mask;
  wire        wr_lane0  = access & pwrite & pstrb[0];
  wire        rd        = access & ~pwrite;
  wire        wr_csra   = wr_lane0 & hit_csra;
  wire        wr_stat   = wr_lane0 & hit_stat;
  wire [7:0]  wbyte     = pwdata[7:0];

  assign pready  = 1'b1;
  assign pslverr = access & ~mapped;

  // Prescaler; codes 0 and 1 both give two
  wire [7:0] div_factor = (prescale_q < 3'h2) ? 8'h02 :
                          8'(8'h01 << prescale_q);
  wire [7:0] div_m1     = 8'(div_factor - 8'h01);
  wire       adc_tick   = enable_q & (div_cnt_q == div_m1[6:0]);

  // Sequencer terms
  wire busy        = state_q == ACC_CONVERT;
  wire conv_end    = busy & adc_tick & (cycle_q == 5'(length_q - 5'h01));
  wire en_next     = wr_csra ? wbyte[`ACC_CSRA_EN] : enable_q;
  // Start written together with enable counts as well
  wire sw_start    = wr_csra & wbyte[`ACC_CSRA_START] &
                     wbyte[`ACC_CSRA_EN];

  // Trigger edge; source zero follows the done flag for free running
  wire [7:0] trig_vec  = {trigger_sources, done_flag_q};
  wire       trig_sig  = trig_vec[trig_src_q];
  wire       to_free   = (trig_src_q == 3'h0) &
                         (trig_src_prev_q != 3'h0);
  wire       trig_edge = trig_sig & ~trig_prev_q & ~to_free;
  wire       hw_start  = auto_trig_q & trig_edge;
  // Starts while busy are dropped, as in the analog core
  wire       start_go  = (sw_start | hw_start) & en_next & ~busy;
  wire       abort     = busy & ~en_next;

  // Done flag: set wins over any of the three clears
  wire flag_clr = irq_vector_ack |
                  (wr_csra & wbyte[`ACC_CSRA_FLAG]) |
                  (wr_stat & wbyte[`ACC_IRQ_DONE]);
  assign done_flag_d  = conv_end | (done_flag_q & ~flag_clr);
  assign abort_flag_d = abort |
                        (abort_flag_q & ~(wr_stat & wbyte[`ACC_IRQ_ABORT]));

  // Result freeze between low and high reads
  wire rd_lo = rd & hit_lo;
  wire rd_hi = rd & hit_hi;

  // Read data
  wire [7:0] csra_rd = {enable_q, busy, auto_trig_q, done_flag_q,
                        irq_en_q, prescale_q};
  wire [7:0] rd_byte =
    hit_trig  ? {5'h00, trig_src_q} :
    hit_lo    ? result_q[7:0] :
    hit_hi    ? {6'h00, result_q[9:8]} :
    hit_csra  ? csra_rd :
    hit_chsel ? chsel_q :
    hit_stat  ? {6'h00, abort_flag_q, done_flag_q} :
    hit_mask  ? {6'h00, mask_q} : 8'h00;
  assign prdata = rd ? {24'h000000, rd_byte} : 32'h00000000;

  // Control and status A
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      enable_q    <= 1'(`ACC_CSRA_RST >> `ACC_CSRA_EN);
      auto_trig_q <= 1'b0;
      irq_en_q    <= 1'b0;
      prescale_q  <= 3'(`ACC_CSRA_RST & 8'h07);
    end
    else if (wr_csra)
    begin
      enable_q    <= wbyte[`ACC_CSRA_EN];
      auto_trig_q <= wbyte[`ACC_CSRA_ATE];
      irq_en_q    <= wbyte[`ACC_CSRA_IE];
      prescale_q  <= wbyte[2:0];
    end
  end

  // Other writable registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      chsel_q    <= `ACC_CHSEL_RST;
      trig_src_q <= `ACC_TRIG_RST;
      mask_q     <= `ACC_MASK_RST;
    end
    else
    begin
      if (wr_lane0 & hit_chsel)
        chsel_q <= wbyte;
      if (wr_lane0 & hit_trig)
        trig_src_q <= wbyte[2:0];
      if (wr_lane0 & hit_mask)
        mask_q <= wbyte[1:0];
    end
  end

  // Flags and trigger history
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_flag_q     <= 1'b0;
      abort_flag_q    <= 1'b0;
      trig_prev_q     <= 1'b0;
      trig_src_prev_q <= 3'h0;
    end
    else
    begin
      done_flag_q     <= done_flag_d;
      abort_flag_q    <= abort_flag_d;
      trig_prev_q     <= trig_sig;
      trig_src_prev_q <= trig_src_q;
    end
  end

  // Prescaler counter; held in reset while the converter is off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      div_cnt_q <= 7'h00;
    else if (!enable_q || adc_tick || start_go)
      div_cnt_q <= 7'h00;
    else
      div_cnt_q <= 7'(div_cnt_q + 7'h01);
  end

  // First-conversion marker, armed while the converter is off or being switched off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_q <= 1'b1;
    else if (!en_next)
      first_q <= 1'b1;
    else if (start_go)
      first_q <= 1'b0;
  end

  // Conversion sequencer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q  <= ACC_IDLE;
      cycle_q  <= 5'h00;
      length_q <= `ACC_NORMAL_CYCLES;
    end
    else
    begin
      case (state_q)
        ACC_IDLE:
        begin
          if (start_go)
          begin
            state_q  <= ACC_CONVERT;
            cycle_q  <= 5'h00;
            length_q <= first_q ? `ACC_FIRST_CYCLES :
                                  `ACC_NORMAL_CYCLES;
          end
        end
        ACC_CONVERT:
        begin
          if (abort || conv_end)
            state_q <= ACC_IDLE;
          else if (adc_tick)
            cycle_q <= 5'(cycle_q + 5'h01);
        end
        default:
          state_q <= ACC_IDLE;
      endcase
    end
  end

  // Selection latched only at start, so later writes wait their turn
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      mux_sel_q      <= '0;
      ref_sel_q      <= 2'h0;
      sample_start_q <= 1'b0;
    end
    else
    begin
      sample_start_q <= start_go;
      if (start_go)
      begin
        mux_sel_q <= decode_sel(chsel_q[5:0]);
        ref_sel_q <= chsel_q[7:6];
      end
    end
  end

  // Result capture, frozen between a low read and a high read
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_q      <= 10'h000;
      result_lock_q <= 1'b0;
    end
    else
    begin
      if (conv_end && !result_lock_q)
        result_q <= core_result;
      if (rd_hi)
        result_lock_q <= 1'b0;
      else if (rd_lo)
        result_lock_q <= 1'b1;
    end
  end

  assign converter_power       = enable_q;
  assign conversion_running    = busy;
  assign sample_start          = sample_start_q;
  assign core_mux_sel          = mux_sel_q;
  assign core_reference_select = ref_sel_q;
  assign irq = (done_flag_q & irq_en_q & global_irq_enable &
                mask_q[`ACC_IRQ_DONE]) |
               (abort_flag_q & mask_q[`ACC_IRQ_ABORT]);

endmodule
